// ### logic/dfx_regs.svh
// Purpose: Named constants for the dual FIFO expansion configuration block.
// Assumes: Included by bare name from the package and the modules.
// Notes: Offsets are in words; widths in bits.
`ifndef DFX_REGS_SVH
`define DFX_REGS_SVH
`define DFX_OFFSET_W 8
`define DFX_DEF_OFFSET 8'h07
`define DFX_DATA_W 9
`define DFX_OFS_IDX_W 2
`define DFX_IDX_EMPTY_LSB 2'h0
`define DFX_IDX_EMPTY_MSB 2'h1
`define DFX_IDX_FULL_LSB 2'h2
`define DFX_IDX_FULL_MSB 2'h3
`define DFX_PAIR_W 18
`endif

// ### logic/dfx_pkg.sv
// Purpose: Types shared by the dual FIFO expansion configuration logic.
// Assumes: dfx_regs.svh supplies the widths.
// Notes: One struct carries a port's control pins, one its resolved config.
`include "dfx_regs.svh"
package dfx_pkg;
  // Mode chosen by the dual-purpose pin at reset
  typedef enum logic [0:0]
  {
    DFX_MODE_LOAD = 1'b0,
    DFX_MODE_WEN2 = 1'b1
  } dfx_mode_e;

  // Raw control pins of one FIFO port
  typedef struct packed
  {
    logic first_write_enable_n;
    logic second_write_enable_or_load;
    logic first_read_enable_n;
    logic second_read_enable_n;
    logic [`DFX_DATA_W-1:0] data;
  } dfx_ctrl_s;

  // Resolved decisions for one FIFO port
  typedef struct packed
  {
    logic fifo_write;
    logic fifo_read;
    logic offset_write;
    logic offset_read;
    logic [2*`DFX_OFFSET_W-1:0] empty_offset;
    logic [2*`DFX_OFFSET_W-1:0] full_offset;
  } dfx_cfg_s;
endpackage

// ### logic/dfx_port_cfg.sv
// Purpose: Mode capture and offset handling for one FIFO port.
// Assumes: Pins are already synchronised to mclk_i by the parent.
// Notes: Offset write and read sequencing share one index pointer.
`include "dfx_regs.svh"
module dfx_port_cfg
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic port_rst_n_i,
  input wire dfx_pkg::dfx_ctrl_s ctrl_i,
  output dfx_pkg::dfx_mode_e mode_o,
  output dfx_pkg::dfx_cfg_s cfg_o,
  output logic [`DFX_DATA_W-1:0] offset_data_o
);
  import dfx_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  dfx_mode_e mode_ff, nxt_mode;                       // Latched pin mode
  logic [`DFX_OFFSET_W-1:0] ofs_ff [4];               // Four offset bytes
  logic [`DFX_OFFSET_W-1:0] nxt_ofs [4];
  logic [`DFX_OFS_IDX_W-1:0] idx_ff, nxt_idx;         // Next offset slot
  logic [`DFX_DATA_W-1:0] odata_ff, nxt_odata;        // Offset readback
  logic load_sel;
  logic in_reset;

  // Reset content of one offset slot: LSB slots hold seven, MSB slots zero
  function automatic logic [`DFX_OFFSET_W-1:0] default_byte(input int slot);
    return (slot[0] == 1'b0) ? `DFX_DEF_OFFSET : '0;
  endfunction

  // Mode, pointer and offset next values
  always_comb
  begin
    in_reset = !port_rst_n_i;
    nxt_mode = mode_ff;
    nxt_idx = idx_ff;
    nxt_odata = odata_ff;
    for (int i = 0; i < 4; i++)
    begin
      nxt_ofs[i] = ofs_ff[i];
    end
    load_sel = (mode_ff == DFX_MODE_LOAD) && !ctrl_i.second_write_enable_or_load;
    if (in_reset)
    begin
      // Pin level during port reset picks the mode; and
      nxt_mode = ctrl_i.second_write_enable_or_load ? DFX_MODE_WEN2 : DFX_MODE_LOAD;
      nxt_idx = `DFX_IDX_EMPTY_LSB;
      for (int i = 0; i < 4; i++)
      begin
        nxt_ofs[i] = default_byte(i);
      end
    end
    else if (load_sel && !ctrl_i.first_write_enable_n)
    begin
      // Write takes priority; simultaneous offset read is illegal anyway
      nxt_ofs[idx_ff] = ctrl_i.data[`DFX_OFFSET_W-1:0];
      nxt_idx = idx_ff + 2'h1;
    end
    else if (load_sel && !ctrl_i.first_read_enable_n && !ctrl_i.second_read_enable_n)
    begin
      nxt_odata = {1'b0, ofs_ff[idx_ff]};
      nxt_idx = idx_ff + 2'h1;
    end
  end

  // Register stage
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      mode_ff <= DFX_MODE_LOAD;
      idx_ff <= '0;
      odata_ff <= '0;
      for (int i = 0; i < 4; i++)
      begin
        ofs_ff[i] <= default_byte(i);
      end
    end
    else
    begin
      mode_ff <= nxt_mode;
      idx_ff <= nxt_idx;
      odata_ff <= nxt_odata;
      for (int i = 0; i < 4; i++)
      begin
        ofs_ff[i] <= nxt_ofs[i];
      end
    end
  end

  // Decode write/read strobes and present thresholds
  always_comb
  begin
    cfg_o.offset_write = load_sel && !ctrl_i.first_write_enable_n && port_rst_n_i;
    cfg_o.offset_read = load_sel && ctrl_i.first_write_enable_n && !ctrl_i.first_read_enable_n
                        && !ctrl_i.second_read_enable_n && port_rst_n_i;
    // Load mode: write when load high and first enable low
    cfg_o.fifo_write = port_rst_n_i && !ctrl_i.first_write_enable_n && ctrl_i.second_write_enable_or_load;
    cfg_o.fifo_read = port_rst_n_i && !ctrl_i.first_read_enable_n && !ctrl_i.second_read_enable_n
                      && !load_sel;
    if (mode_ff == DFX_MODE_WEN2)
    begin
      // Offsets cannot load in this mode, so defaults apply
      cfg_o.empty_offset = {8'h00, `DFX_DEF_OFFSET};
      cfg_o.full_offset = {8'h00, `DFX_DEF_OFFSET};
    end
    else
    begin
      cfg_o.empty_offset = {ofs_ff[`DFX_IDX_EMPTY_MSB], ofs_ff[`DFX_IDX_EMPTY_LSB]};
      cfg_o.full_offset = {ofs_ff[`DFX_IDX_FULL_MSB], ofs_ff[`DFX_IDX_FULL_LSB]};
    end
  end

  assign mode_o = mode_ff;
  assign offset_data_o = odata_ff;

  // Second-enable mode never shows programmed thresholds
  wen2_defaults_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (mode_o == DFX_MODE_WEN2) |-> (cfg_o.empty_offset == 16'h0007 && cfg_o.full_offset == 16'h0007))
    else $error("default offsets not used in second enable mode");
endmodule

// ### logic/dfx_top.sv
// Purpose: Configuration logic for a pair of independent FIFOs (A and B).
// Assumes: Single clock mclk_i; pins arrive asynchronously and are synchronised.
// Notes: Storage and flag arithmetic live in the core; this block decides roles.
`include "dfx_regs.svh"
// Functional notes
// - Load pin low at reset selects offset access
// - Load pin high at reset: second write enable
// - Second enable mode uses default offsets
// - FIFO A carries A to B, B carries B to A
// - Unprogrammed offsets default to seven
// - Write when first enable low, second high
module dfx_top
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic port_a_rst_n_i,
  input wire logic port_b_rst_n_i,
  input wire dfx_pkg::dfx_ctrl_s port_a_ctrl_i,
  input wire dfx_pkg::dfx_ctrl_s port_b_ctrl_i,
  input wire logic port_a_empty_flag_i,
  input wire logic port_b_empty_flag_i,
  input wire logic port_a_full_flag_i,
  input wire logic port_b_full_flag_i,
  output dfx_pkg::dfx_mode_e port_a_mode_o,
  output dfx_pkg::dfx_mode_e port_b_mode_o,
  output dfx_pkg::dfx_cfg_s port_a_cfg_o,
  output dfx_pkg::dfx_cfg_s port_b_cfg_o,
  output logic [`DFX_DATA_W-1:0] port_a_offset_data_o,
  output logic [`DFX_DATA_W-1:0] port_b_offset_data_o,
  output logic composite_empty_n_o,
  output logic composite_full_n_o
);
  import dfx_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers for all pin inputs
  // Each bit is caught alone, so a multi-pin change may land split across one edge;
  // hosts hold each offset access for one edge only, as the decode steps the offset index on every edge it sees one
  localparam int SYNC_W = 2 * $bits(dfx_ctrl_s) + 6;
  logic [SYNC_W-1:0] meta_ff, nxt_meta;   // First stage, read only by sync_ff
  logic [SYNC_W-1:0] sync_ff, nxt_sync;   // Second stage, safe to use
  logic [SYNC_W-1:0] pins;
  dfx_ctrl_s a_ctrl, b_ctrl;
  logic a_rst_n, b_rst_n, a_ef_n, b_ef_n, a_ff_n, b_ff_n;
  logic comp_e_ff, nxt_comp_e, comp_f_ff, nxt_comp_f;

  // Elaboration check: offsets load through the data pins, and two words form one pair word
  if (`DFX_OFFSET_W > `DFX_DATA_W || 2 * `DFX_DATA_W != `DFX_PAIR_W)
  begin : g_bad_widths
    $error("offset or pair width does not fit the data pins");
  end

  // Gather pins and step the synchroniser
  always_comb
  begin
    pins = {port_a_ctrl_i, port_b_ctrl_i, port_a_rst_n_i, port_b_rst_n_i,
            port_a_empty_flag_i, port_b_empty_flag_i, port_a_full_flag_i, port_b_full_flag_i};
    nxt_meta = pins;
    nxt_sync = meta_ff;
  end

  // Synchroniser registers; reset holds ports in reset and flags asserted
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign {a_ctrl, b_ctrl, a_rst_n, b_rst_n, a_ef_n, b_ef_n, a_ff_n, b_ff_n} = sync_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Each FIFO is configured on its own; A runs A->B, B runs B->A
  dfx_port_cfg u_port_a
  (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .port_rst_n_i(a_rst_n),
    .ctrl_i(a_ctrl),
    .mode_o(port_a_mode_o),
    .cfg_o(port_a_cfg_o),
    .offset_data_o(port_a_offset_data_o)
  );

  dfx_port_cfg u_port_b
  (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .port_rst_n_i(b_rst_n),
    .ctrl_i(b_ctrl),
    .mode_o(port_b_mode_o),
    .cfg_o(port_b_cfg_o),
    .offset_data_o(port_b_offset_data_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Composite flags for width-expansion users
  // Either active-low flag asserts the composite
  always_comb
  begin
    nxt_comp_e = a_ef_n && b_ef_n;
    nxt_comp_f = a_ff_n && b_ff_n;
  end

  // Flag registers start asserted, the safe state before FIFOs are known
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      comp_e_ff <= 1'b0;
      comp_f_ff <= 1'b0;
    end
    else
    begin
      comp_e_ff <= nxt_comp_e;
      comp_f_ff <= nxt_comp_f;
    end
  end

  assign composite_empty_n_o = comp_e_ff;
  assign composite_full_n_o = comp_f_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Mode follows the synchronised pin level while the port is in reset
  mode_load_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (!a_rst_n && !a_ctrl.second_write_enable_or_load) |=> (port_a_mode_o == DFX_MODE_LOAD))
    else $error("port A did not enter load mode");

  mode_wen2_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (!b_rst_n && b_ctrl.second_write_enable_or_load) |=> (port_b_mode_o == DFX_MODE_WEN2))
    else $error("port B did not enter second enable mode");

  // Mode holds once reset is released
  mode_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (a_rst_n && $past(a_rst_n)) |-> $stable(port_a_mode_o))
    else $error("port A mode changed outside reset");

  // FIFO write strobe exact decode in second enable mode
  fifo_write_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (a_rst_n && port_a_mode_o == DFX_MODE_WEN2) |->
    (port_a_cfg_o.fifo_write == (!a_ctrl.first_write_enable_n && a_ctrl.second_write_enable_or_load)))
    else $error("port A write strobe wrong");

  // Offsets restored to seven by a port reset
  offset_default_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (!b_rst_n) |=> (port_b_cfg_o.empty_offset == 16'h0007 && port_b_cfg_o.full_offset == 16'h0007))
    else $error("port B offsets not defaulted");

  // Composite empty tracks both flags one edge later
  comp_empty_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (!a_ef_n || !b_ef_n) |=> !composite_empty_n_o)
    else $error("composite empty missed a flag");

  comp_full_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (a_ff_n && b_ff_n) |=> composite_full_n_o)
    else $error("composite full asserted wrongly");

  // Offset write never overlaps a FIFO write
  no_overlap_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !(port_a_cfg_o.offset_write && port_a_cfg_o.fifo_write))
    else $error("offset and FIFO write together");

  // Port B enters load mode the same way as port A
  b_load_mode_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (!b_rst_n && !b_ctrl.second_write_enable_or_load) |=> (port_b_mode_o == DFX_MODE_LOAD))
    else $error("port B did not enter load mode");

  // Port A enters second enable mode the same way as port B
  a_wen2_mode_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (!a_rst_n && a_ctrl.second_write_enable_or_load) |=> (port_a_mode_o == DFX_MODE_WEN2))
    else $error("port A did not enter second enable mode");

  // Port B mode also holds once its reset is released
  b_mode_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (b_rst_n && $past(b_rst_n)) |-> $stable(port_b_mode_o))
    else $error("port B mode changed outside reset");

  // Port B write strobe follows both enables in second enable mode
  b_fifo_write_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (b_rst_n && port_b_mode_o == DFX_MODE_WEN2) |->
    (port_b_cfg_o.fifo_write == (!b_ctrl.first_write_enable_n && b_ctrl.second_write_enable_or_load)))
    else $error("port B write strobe wrong");

  // No offset access at all once second enable mode is latched
  a_no_load_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (port_a_mode_o == DFX_MODE_WEN2) |->
    !(port_a_cfg_o.offset_write || port_a_cfg_o.offset_read))
    else $error("port A offset access in second enable mode");

  b_no_load_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (port_b_mode_o == DFX_MODE_WEN2) |->
    !(port_b_cfg_o.offset_write || port_b_cfg_o.offset_read))
    else $error("port B offset access in second enable mode");

  // Port A offsets are restored to seven as well
  a_offset_default_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (!a_rst_n) |=> (port_a_cfg_o.empty_offset == 16'h0007 && port_a_cfg_o.full_offset == 16'h0007))
    else $error("port A offsets not defaulted");

  // Load low with first enable low must reach the offset registers
  a_offset_write_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (a_rst_n && port_a_mode_o == DFX_MODE_LOAD && !a_ctrl.second_write_enable_or_load
    && !a_ctrl.first_write_enable_n) |-> port_a_cfg_o.offset_write)
    else $error("port A offset write strobe missing");

  // Composite full asserts when either full flag asserts
  comp_full_miss_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (!a_ff_n || !b_ff_n) |=> !composite_full_n_o)
    else $error("composite full missed a flag");

  // Composite empty releases only when both halves hold data
  comp_empty_clr_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (a_ef_n && b_ef_n) |=> composite_empty_n_o)
    else $error("composite empty held wrongly");
endmodule

// ### verification/dfx_host.sv
// Purpose: Host processors and expansion logic facing both FIFO ports.
// Assumes: The bench hands requests in at a rising edge.
// Notes: Pins are registered here, so they land one edge after the request.
module dfx_host
(
  input wire logic mclk_i,
  input wire logic shared_i,
  input wire dfx_pkg::dfx_ctrl_s a_i,
  input wire dfx_pkg::dfx_ctrl_s b_i,
  output dfx_pkg::dfx_ctrl_s a_ctrl_o,
  output dfx_pkg::dfx_ctrl_s b_ctrl_o
);
  import dfx_pkg::*;
  dfx_ctrl_s nxt_a; // Next pins of port A
  dfx_ctrl_s nxt_b; // Next pins of port B
  ////////////////////////////////////////////////////////////////
  // Second read enable is grounded; in width mode B copies A's pins
  always_comb
  begin
    nxt_a = a_i;
    nxt_a.second_read_enable_n = 1'b0;
    nxt_b = shared_i ? a_i : b_i;
    nxt_b.second_read_enable_n = 1'b0;
  end
  // Registered so every pin change is aligned to one edge
  always_ff @(posedge mclk_i)
  begin
    a_ctrl_o <= nxt_a;
    b_ctrl_o <= nxt_b;
  end
endmodule

// ### verification/tb.sv
// Purpose: Self-checking bench for the dual FIFO configuration block.
// Assumes: Pin paths take host 1 edge plus sync 2 edges.
// Notes: Waits are fixed latencies from the hand-over timing.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dfx_pkg::*;
  logic mclk_i, rst_n_i, pa_rst_n, pb_rst_n, shared; // Clock, resets, width mode
  logic ea_n, eb_n, fa_n, fb_n; // Raw FIFO flags
  dfx_ctrl_s a_req, b_req, a_ctrl, b_ctrl; // Requests and pins
  dfx_mode_e a_mode, b_mode; // Captured modes
  dfx_cfg_s a_cfg, b_cfg; // Resolved decisions
  logic [8:0] a_ofs, b_ofs; // Offset readback
  logic ce_n, cf_n; // Composite flags
  int err_count, comparisons;
  localparam dfx_ctrl_s IDLE = 13'h1E00; // All enables inactive, load high
  ////////////////////////////////////////////////////////////////
  dfx_host host (.mclk_i(mclk_i), .shared_i(shared), .a_i(a_req), .b_i(b_req), .a_ctrl_o(a_ctrl),
    .b_ctrl_o(b_ctrl));
  dfx_top dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .port_a_rst_n_i(pa_rst_n), .port_b_rst_n_i(pb_rst_n),
    .port_a_ctrl_i(a_ctrl), .port_b_ctrl_i(b_ctrl), .port_a_empty_flag_i(ea_n), .port_b_empty_flag_i(eb_n),
    .port_a_full_flag_i(fa_n), .port_b_full_flag_i(fb_n), .port_a_mode_o(a_mode), .port_b_mode_o(b_mode),
    .port_a_cfg_o(a_cfg), .port_b_cfg_o(b_cfg), .port_a_offset_data_o(a_ofs),
    .port_b_offset_data_o(b_ofs), .composite_empty_n_o(ce_n), .composite_full_n_o(cf_n));
  ////////////////////////////////////////////////////////////////
  // Pin word: first write enable, load, first read enable, data
  function automatic dfx_ctrl_s mk(logic w, logic l, logic r, logic [8:0] d);
    return {w, l, r, 1'b1, d};
  endfunction
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  // Let n edges pass, then sample once outputs settle
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  // Port reset with the dual-purpose pin held at ld
  task automatic prst(input logic ld, input logic sh);
    @(posedge mclk_i);
    shared <= sh;
    a_req <= mk(1'b1, ld, 1'b1, 9'h000);
    b_req <= mk(1'b1, ld, 1'b1, 9'h000);
    pa_rst_n <= 1'b0;
    pb_rst_n <= 1'b0;
    repeat (6) @(posedge mclk_i);
    pa_rst_n <= 1'b1;
    pb_rst_n <= 1'b1;
    // Pins must outlast the synced reset, hence the long hold
    repeat (6) @(posedge mclk_i);
    a_req <= IDLE;
    b_req <= IDLE;
  endtask
  ////////////////////////////////////////////////////////////////
  // Load mode in width expansion: defaults, four offset writes, readback
  task automatic t_load;
    prst(1'b0, 1'b1);
    cyc(2);
    chk(a_mode, DFX_MODE_LOAD);
    chk(b_cfg.empty_offset, 16'h0007);
    chk(a_cfg.full_offset, 16'h0007);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge mclk_i);
      a_req <= mk(1'b0, 1'b0, 1'b1, 9'(8'h21 + 8'h22 * i));
    end
    @(posedge mclk_i);
    a_req <= IDLE;
    cyc(2);
    chk(a_cfg.offset_write, 1'b1);
    chk(a_cfg.fifo_write, 1'b0);
    cyc(4);
    chk(a_cfg.empty_offset, 16'h4321);
    chk(b_cfg.empty_offset, 16'h4321);
    chk(b_cfg.full_offset, 16'h8765);
    // Index has wrapped, so the read returns the empty LSB
    @(posedge mclk_i);
    a_req <= mk(1'b1, 1'b0, 1'b0, 9'h000);
    @(posedge mclk_i);
    a_req <= IDLE;
    cyc(2);
    chk(a_cfg.offset_read, 1'b1);
    chk(a_cfg.fifo_read, 1'b0);
    cyc(4);
    chk(a_ofs, 9'h021);
    chk(b_ofs, 9'h021);
    @(posedge mclk_i);
    a_req <= mk(1'b0, 1'b1, 1'b1, 9'h1AA);
    cyc(4);
    chk(b_cfg.fifo_write, 1'b1);
    chk(a_cfg.fifo_read, 1'b0);
    @(posedge mclk_i);
    a_req <= mk(1'b1, 1'b1, 1'b0, 9'h000);
    cyc(4);
    chk(a_cfg.fifo_read, 1'b1);
    chk(b_cfg.fifo_write, 1'b0);
    @(posedge mclk_i);
    a_req <= IDLE;
    $display("test load mode done");
  endtask
  // Second write enable mode with independent ports
  task automatic t_wen2;
    prst(1'b1, 1'b0);
    cyc(2);
    chk(a_mode, DFX_MODE_WEN2);
    chk(b_mode, DFX_MODE_WEN2);
    @(posedge mclk_i);
    a_req <= mk(1'b0, 1'b1, 1'b1, 9'h000);
    cyc(4);
    chk(a_cfg.fifo_write, 1'b1);
    chk(b_cfg.fifo_write, 1'b0);
    @(posedge mclk_i);
    a_req <= mk(1'b0, 1'b0, 1'b1, 9'h055);
    cyc(4);
    chk(a_cfg.fifo_write, 1'b0);
    chk(a_cfg.offset_write, 1'b0);
    @(posedge mclk_i);
    a_req <= IDLE;
    cyc(4);
    chk(a_cfg.empty_offset, 16'h0007);
    chk(a_cfg.full_offset, 16'h0007);
    $display("test second enable mode done");
  endtask
  // Composite flags over every pairing of the two halves
  task automatic t_comp;
    for (int i = 0; i < 4; i++)
    begin
      @(posedge mclk_i);
      {ea_n, eb_n} <= i[1:0];
      {fa_n, fb_n} <= ~i[1:0];
      cyc(5);
      chk(ce_n, ea_n & eb_n);
      chk(cf_n, fa_n & fb_n);
    end
    $display("test composite flags done");
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Free-running 125 MHz clock
  initial
  begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end
  // Guard against a hang
  initial
  begin
    #100000;
    err_count++;
    close_out();
  end
  // Main sequence
  initial
  begin
    {rst_n_i, pa_rst_n, pb_rst_n, shared, ea_n, eb_n, fa_n, fb_n} = 8'h00;
    a_req = IDLE;
    b_req = IDLE;
    err_count = 0;
    comparisons = 0;
    repeat (10) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    t_load();
    t_wen2();
    t_comp();
    close_out();
  end
endmodule
